//--- ctp_cache_path.sv
// two-set cache data path, lookup control and block transfer sequencing
// How it works
// - two data sets of 256 blocks, each eight 16-bit words
// - miss fetches the whole block as four 32-bit double words
// - ram input takes cpu write data when write and idle state
// - ram address comes from latched cpu or snoop address, or fill counter
// - four active-low write enables chosen by hit set and word half on cpu write, both halves of the victim set on fill
// - cpu read multiplexer decodes C,B,A per the seven-way table
// - source code reaches cpu read bus when its select is set
// - parity bits of the read word are high on even parity
// - bus output mux: set B when lru select low, A when high
// - fill stores tag field in entry indexed by index field
// - each access compares both stored tags; match enables that set
// - both sets hitting on a cpu lookup or a snoop raises the double hit error
// - idle state drives latched cpu address to tag and ram lookup
// - hit keeps dirty hit inactive, no bus opcode, fail low
// - clean miss goes through receive state to fetch the block
// - dirty miss writes back in send state, then receives
// - bus transactions are compared against held blocks
// - foreign read of a dirty held block is served by this block
// - idle service state is the default and serves cpu hits
// - miss raises fail; cpu holds start and write until done
// - without fail the cpu takes the word and drops start
module ctp_cache_path #(
	parameter int BLOCKS = ctp_pkg::BLOCKS
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic cpu_start_i,
	input wire logic cpu_write_i,
	input wire logic [31:0] cpu_address_bus_i,
	input wire logic [15:0] cpu_write_data_bus_i,
	input wire logic message_upper_select_i,
	input wire logic message_lower_select_i,
	input wire logic source_code_select_i,
	input wire logic [31:0] message_word_i,
	input wire logic [15:0] source_code_i,
	input wire logic bus_grant_i,
	input wire logic fill_valid_i,
	input wire logic [31:0] fill_in_bus_i,
	input wire logic bus_data_take_i,
	input wire logic snoop_valid_i,
	input wire logic snoop_read_i,
	output logic [15:0] cpu_read_data_bus_o,
	output logic [1:0] parity_o,
	output logic cpu_done_o,
	output logic fail_o,
	output logic double_hit_error_o,
	output logic dirty_hit_n_o,
	output logic abort_o,
	output logic bus_request_o,
	output ctp_pkg::ctp_busop_t bus_opcode_o,
	output logic [31:0] bus_address_o,
	output logic [31:0] bus_out_data_o,
	output logic bus_out_valid_o,
	output logic lru_set_select_o,
	output logic set_a_upper_write_en_n_o,
	output logic set_a_lower_write_en_n_o,
	output logic set_b_upper_write_en_n_o,
	output logic set_b_lower_write_en_n_o
);
	localparam int RAM_DEPTH = BLOCKS * 4;
	localparam int RAM_AW = ctp_pkg::IDX_W + ctp_pkg::DW_W;

	ctp_tag_if tif ();
	ctp_tag_store #(.BLOCKS(BLOCKS)) u_tags (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i),
		.tif(tif)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ctp_pkg::ctp_state_t st_r, st_nxt, ret_r, ret_nxt;
	logic [31:0] cpu_address_latch_r, cpu_address_latch_nxt;
	logic [31:0] snoop_addr_r, snoop_addr_nxt;
	logic pend_r, pend_nxt, start_q_r, snoop_rd_r, snoop_rd_nxt;
	logic wb_r, wb_nxt, vict_r, vict_nxt, out_sel_r, out_sel_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt, abort_r, abort_nxt;
	logic [ctp_pkg::DWORD_W-1:0] ram_r [2][RAM_DEPTH];
	logic [15:0] rd_data_r, mux_out;
	logic [1:0] par_r;
	logic [31:0] bus_data_r, bus_addr_r, bus_addr_nxt, din;
	logic [31:0] look_addr;
	logic [RAM_AW-1:0] ram_addr, out_addr;
	logic [2:0] mux_sel;
	logic cpu_look, any_hit, miss, victim, victim_dirty, half, hit_b;
	logic cpu_we, rcv_we, set_sel_nxt, snoop_dirty_hit;
	logic [1:0] up_n, lo_n;

	// ------------------------------------------------------------
	// lookup address and tag compare
	// ------------------------------------------------------------
	assign look_addr = (st_r == ctp_pkg::ST_SNOOP ||
		st_r == ctp_pkg::ST_ACT_MEM) ? snoop_addr_r
		: cpu_address_latch_r;
	assign tif.index = look_addr[ctp_pkg::IDX_LSB +: ctp_pkg::IDX_W];
	assign tif.tag = look_addr[ctp_pkg::TAG_LSB +: ctp_pkg::TAG_W];
	assign any_hit = |tif.hit;
	assign hit_b = tif.hit[1];
	assign half = look_addr[ctp_pkg::HALF_BIT];
	assign cpu_look = pend_r && (st_r == ctp_pkg::ST_IDLE);
	assign miss = cpu_look && !any_hit;
	// lru high points at set A as the next one to replace
	assign victim = !tif.lru;
	assign victim_dirty = tif.valid[victim] && tif.dirty[victim];
	assign snoop_dirty_hit = (st_r == ctp_pkg::ST_SNOOP) && snoop_rd_r &&
		|(tif.hit & tif.dirty);
	assign double_hit_error_o = (&tif.hit) && (cpu_look ||
		st_r == ctp_pkg::ST_SNOOP);

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		ret_nxt = ret_r;
		cpu_address_latch_nxt = cpu_address_latch_r;
		snoop_addr_nxt = snoop_addr_r;
		snoop_rd_nxt = snoop_rd_r;
		pend_nxt = pend_r;
		wb_nxt = wb_r;
		vict_nxt = vict_r;
		out_sel_nxt = out_sel_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		abort_nxt = 1'b0;
		tif.op_set = hit_b;
		tif.fill_we = 1'b0;
		tif.inval_we = 1'b0;
		tif.dirty_set_we = 1'b0;
		tif.dirty_clr_we = 1'b0;
		tif.lru_we = 1'b0;
		tif.lru_val = 1'b0;
		// a new request is a rising start seen while no request is pending
		if (cpu_start_i && !start_q_r && !pend_r) begin
			pend_nxt = 1'b1;
			cpu_address_latch_nxt = cpu_address_bus_i;
		end
		if (snoop_valid_i && (st_r == ctp_pkg::ST_IDLE ||
			st_r == ctp_pkg::ST_WAIT_BUS)) begin
			snoop_addr_nxt = fill_in_bus_i;
			snoop_rd_nxt = snoop_read_i;
			ret_nxt = st_r;
			st_nxt = ctp_pkg::ST_SNOOP;
		end
		case (st_r)
			ctp_pkg::ST_IDLE: begin
				if (cpu_look && any_hit) begin
					pend_nxt = 1'b0;
					done_nxt = 1'b1;
					tif.dirty_set_we = cpu_write_i;
					tif.lru_we = 1'b1;
					tif.lru_val = hit_b;
				end else if (miss && !snoop_valid_i) begin
					vict_nxt = victim;
					wb_nxt = victim_dirty;
					st_nxt = ctp_pkg::ST_WAIT_BUS;
				end
			end
			ctp_pkg::ST_WAIT_BUS: begin
				if (bus_grant_i && !snoop_valid_i) begin
					cnt_nxt = 2'h0;
					st_nxt = wb_r ? ctp_pkg::ST_SEND
						: ctp_pkg::ST_RECEIVE;
				end
			end
			ctp_pkg::ST_SEND: begin
				tif.op_set = vict_r;
				if (bus_data_take_i) begin
					cnt_nxt = cnt_r + 2'h1;
					if (cnt_r == ctp_pkg::LAST_DWORD) begin
						wb_nxt = 1'b0;
						tif.dirty_clr_we = 1'b1;
						st_nxt = ctp_pkg::ST_WAIT_BUS;
					end
				end
			end
			ctp_pkg::ST_RECEIVE: begin
				tif.op_set = vict_r;
				if (fill_valid_i) begin
					cnt_nxt = cnt_r + 2'h1;
					if (cnt_r == ctp_pkg::LAST_DWORD) begin
						tif.fill_we = 1'b1;
						tif.lru_we = 1'b1;
						tif.lru_val = vict_r;
						st_nxt = ctp_pkg::ST_IDLE;
					end
				end
			end
			ctp_pkg::ST_SNOOP: begin
				st_nxt = ret_r;
				if (any_hit) begin
					tif.inval_we = 1'b1;
				end
				if (snoop_dirty_hit) begin
					abort_nxt = 1'b1;
					out_sel_nxt = hit_b;
					cnt_nxt = 2'h0;
					st_nxt = ctp_pkg::ST_ACT_MEM;
				end
			end
			ctp_pkg::ST_ACT_MEM: begin
				if (bus_data_take_i) begin
					cnt_nxt = cnt_r + 2'h1;
					if (cnt_r == ctp_pkg::LAST_DWORD) begin
						st_nxt = ret_r;
					end
				end
			end
			default: begin
				st_nxt = ctp_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st_r <= ctp_pkg::ST_IDLE;
			ret_r <= ctp_pkg::ST_IDLE;
			cpu_address_latch_r <= 32'h0000_0000;
			snoop_addr_r <= 32'h0000_0000;
			snoop_rd_r <= 1'b0;
			pend_r <= 1'b0;
			start_q_r <= 1'b0;
			wb_r <= 1'b0;
			vict_r <= 1'b0;
			out_sel_r <= 1'b0;
			cnt_r <= 2'h0;
			done_r <= 1'b0;
			abort_r <= 1'b0;
		end else if (clk_en_i) begin
			st_r <= st_nxt;
			ret_r <= ret_nxt;
			cpu_address_latch_r <= cpu_address_latch_nxt;
			snoop_addr_r <= snoop_addr_nxt;
			snoop_rd_r <= snoop_rd_nxt;
			pend_r <= pend_nxt;
			start_q_r <= cpu_start_i;
			wb_r <= wb_nxt;
			vict_r <= vict_nxt;
			out_sel_r <= out_sel_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			abort_r <= abort_nxt;
		end
	end

	// ------------------------------------------------------------
	// data set rams, input mux and write enables
	// ------------------------------------------------------------
	assign din = (cpu_write_i && st_r == ctp_pkg::ST_IDLE) ?
		{cpu_write_data_bus_i, cpu_write_data_bus_i} : fill_in_bus_i;
	assign ram_addr = {tif.index, (st_r == ctp_pkg::ST_RECEIVE) ? cnt_r
		: look_addr[ctp_pkg::DW_LSB +: ctp_pkg::DW_W]};
	assign cpu_we = cpu_look && cpu_write_i && any_hit;
	assign rcv_we = (st_r == ctp_pkg::ST_RECEIVE) && fill_valid_i;
	always_comb begin
		for (int s = 0; s < ctp_pkg::SETS; s++) begin
			up_n[s] = !((cpu_we && tif.hit[s] && !half) ||
				(rcv_we && (vict_r == s[0])));
			lo_n[s] = !((cpu_we && tif.hit[s] && half) ||
				(rcv_we && (vict_r == s[0])));
		end
	end
	assign set_a_upper_write_en_n_o = up_n[0];
	assign set_a_lower_write_en_n_o = lo_n[0];
	assign set_b_upper_write_en_n_o = up_n[1];
	assign set_b_lower_write_en_n_o = lo_n[1];

	always_ff @(posedge core_clk_i) begin
		if (clk_en_i) begin
			for (int s = 0; s < ctp_pkg::SETS; s++) begin
				if (!up_n[s]) begin
					ram_r[s][ram_addr][31:16] <= din[31:16];
				end
				if (!lo_n[s]) begin
					ram_r[s][ram_addr][15:0] <= din[15:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// cpu read multiplexer and parity
	// ------------------------------------------------------------
	always_comb begin
		if (source_code_select_i) begin
			mux_sel = ctp_pkg::SEL_SRC;
		end else if (message_upper_select_i) begin
			mux_sel = ctp_pkg::SEL_MSG_UP;
		end else if (message_lower_select_i) begin
			mux_sel = ctp_pkg::SEL_MSG_LO;
		end else begin
			mux_sel = {1'b0, hit_b, hit_b ? !half : half};
		end
		case (mux_sel)
			ctp_pkg::SEL_A_UP: mux_out = ram_r[0][ram_addr][31:16];
			ctp_pkg::SEL_A_LO: mux_out = ram_r[0][ram_addr][15:0];
			ctp_pkg::SEL_B_LO: mux_out = ram_r[1][ram_addr][15:0];
			ctp_pkg::SEL_B_UP: mux_out = ram_r[1][ram_addr][31:16];
			ctp_pkg::SEL_MSG_UP: mux_out = message_word_i[31:16];
			ctp_pkg::SEL_MSG_LO: mux_out = message_word_i[15:0];
			ctp_pkg::SEL_SRC: mux_out = source_code_i;
			default: mux_out = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// bus side: output mux reads ahead so data is ready on entry
	// ------------------------------------------------------------
	assign set_sel_nxt = (st_nxt == ctp_pkg::ST_ACT_MEM) ? out_sel_nxt
		: vict_nxt;
	assign out_addr = {tif.index, cnt_nxt};
	assign bus_addr_nxt = wb_nxt ? {ctp_pkg::ADDR_TOP_ZERO, tif.tag_q[vict_nxt],
		tif.index, cnt_nxt, 1'b0} : {cpu_address_latch_r[31:3], cnt_nxt, 1'b0};
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rd_data_r <= 16'h0000;
			par_r <= 2'h3;
			bus_data_r <= 32'h0000_0000;
			bus_addr_r <= 32'h0000_0000;
		end else if (clk_en_i) begin
			rd_data_r <= mux_out;
			par_r <= {~^mux_out[15:8], ~^mux_out[7:0]};
			bus_data_r <= set_sel_nxt ? ram_r[1][out_addr]
				: ram_r[0][out_addr];
			bus_addr_r <= bus_addr_nxt;
		end
	end

	assign cpu_read_data_bus_o = rd_data_r;
	assign parity_o = par_r;
	assign cpu_done_o = done_r;
	assign fail_o = pend_r && !(cpu_look && any_hit);
	assign dirty_hit_n_o = !snoop_dirty_hit;
	assign abort_o = abort_r;
	assign bus_request_o = (st_r == ctp_pkg::ST_WAIT_BUS);
	assign bus_opcode_o = (st_r != ctp_pkg::ST_WAIT_BUS) ? ctp_pkg::BUSOP_NONE
		: wb_r ? ctp_pkg::BUSOP_WRITE_BACK : ctp_pkg::BUSOP_READ_PRIV;
	assign bus_address_o = bus_addr_r;
	assign bus_out_data_o = bus_data_r;
	assign bus_out_valid_o = (st_r == ctp_pkg::ST_SEND ||
		st_r == ctp_pkg::ST_ACT_MEM);
	assign lru_set_select_o = (st_r == ctp_pkg::ST_ACT_MEM) ? !out_sel_r
		: !vict_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i iff clk_en_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_clean_miss;
		miss && !snoop_valid_i && !victim_dirty;
	endsequence
	sequence s_dirty_miss;
		miss && !snoop_valid_i && victim_dirty;
	endsequence
	sequence s_last_fill;
		st_r == ctp_pkg::ST_RECEIVE && fill_valid_i && cnt_r == 2'h3;
	endsequence

	a_clean_miss_read: assert property (s_clean_miss |=>
		bus_request_o && bus_opcode_o == ctp_pkg::BUSOP_READ_PRIV)
		else $error("clean miss did not request a block read");
	a_dirty_miss_wb: assert property (s_dirty_miss |=>
		bus_opcode_o == ctp_pkg::BUSOP_WRITE_BACK)
		else $error("dirty miss did not request a write back");
	a_fill_then_hit: assert property (s_last_fill ##1
		(st_r == ctp_pkg::ST_IDLE && !snoop_valid_i) |-> any_hit && !fail_o)
		else $error("filled block missed on return to idle");
	a_hit_quiet: assert property ((cpu_look && any_hit) |->
		!fail_o && dirty_hit_n_o && bus_opcode_o == ctp_pkg::BUSOP_NONE
		##1 cpu_done_o)
		else $error("hit raised fail or bus activity");
	a_miss_fails: assert property (miss |-> fail_o)
		else $error("miss without fail");
	a_double_hit: assert property ((&tif.hit && cpu_look) |->
		double_hit_error_o)
		else $error("double hit not flagged");
	a_parity_even: assert property (parity_o ==
		{~^cpu_read_data_bus_o[15:8], ~^cpu_read_data_bus_o[7:0]})
		else $error("parity bits disagree with read word");
	a_source_code: assert property (source_code_select_i |=>
		cpu_read_data_bus_o == $past(source_code_i))
		else $error("source code not routed to cpu");
	a_write_hit_one_en: assert property (cpu_we |->
		$countones({up_n, lo_n}) == 3)
		else $error("write hit did not enable exactly one half");
	a_write_mux_cpu: assert property ((cpu_we && !hit_b) |=>
		($past(half) ? ram_r[0][$past(ram_addr)][15:0]
		: ram_r[0][$past(ram_addr)][31:16]) == $past(cpu_write_data_bus_i))
		else $error("cpu write data not stored");
	a_reset_idle: assert property ($rose(rst_n_i) |->
		st_r == ctp_pkg::ST_IDLE && !fail_o && !bus_request_o)
		else $error("not idle after reset");
endmodule

//--- ctp_pkg.sv
// shared constants and types of the two-set cache data and tag path
package ctp_pkg;
	// ------------------------------------------------------------
	// address layout (bit 31 of the cpu numbering is bit 0 here)
	// ------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int WORD_W = 16;
	localparam int DWORD_W = 32;
	localparam int TAG_LSB = 11;
	localparam int TAG_W = 16;
	localparam int IDX_LSB = 3;
	localparam int IDX_W = 8;
	localparam int DW_LSB = 1;
	localparam int DW_W = 2;
	localparam int HALF_BIT = 0;
	localparam int BLOCKS = 256;
	localparam int SETS = 2;
	localparam logic [1:0] LAST_DWORD = 2'h3;
	localparam logic [4:0] ADDR_TOP_ZERO = 5'h00;
	// ------------------------------------------------------------
	// select codes C,B,A of the cpu read multiplexer
	// ------------------------------------------------------------
	localparam logic [2:0] SEL_A_UP = 3'h0;
	localparam logic [2:0] SEL_A_LO = 3'h1;
	localparam logic [2:0] SEL_B_LO = 3'h2;
	localparam logic [2:0] SEL_B_UP = 3'h3;
	localparam logic [2:0] SEL_MSG_UP = 3'h4;
	localparam logic [2:0] SEL_MSG_LO = 3'h5;
	localparam logic [2:0] SEL_SRC = 3'h7;
	// ------------------------------------------------------------
	// states and bus operations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT_BUS, ST_SEND, ST_RECEIVE, ST_SNOOP, ST_ACT_MEM
	} ctp_state_t;
	typedef enum logic [1:0] {
		BUSOP_NONE, BUSOP_READ_PRIV, BUSOP_WRITE_BACK
	} ctp_busop_t;
endpackage

//--- ctp_tag_if.sv
// carrier between the path controller and the tag store
interface ctp_tag_if;
	logic [ctp_pkg::IDX_W-1:0] index;
	logic [ctp_pkg::TAG_W-1:0] tag;
	logic op_set;
	logic fill_we;
	logic inval_we;
	logic dirty_set_we;
	logic dirty_clr_we;
	logic lru_we;
	logic lru_val;
	logic [1:0] hit;
	logic [1:0] valid;
	logic [1:0] dirty;
	logic lru;
	logic [ctp_pkg::TAG_W-1:0] tag_q [2];
	modport ctl (output index, tag, op_set, fill_we, inval_we, dirty_set_we,
		dirty_clr_we, lru_we, lru_val, input hit, valid, dirty, lru, tag_q);
	modport store (input index, tag, op_set, fill_we, inval_we, dirty_set_we,
		dirty_clr_we, lru_we, lru_val, output hit, valid, dirty, lru, tag_q);
endinterface

//--- ctp_tag_store.sv
// tag, valid, dirty and lru storage with the two tag comparators
module ctp_tag_store #(
	parameter int BLOCKS = ctp_pkg::BLOCKS
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	ctp_tag_if.store tif
);
	logic [ctp_pkg::TAG_W-1:0] tag_r [2][BLOCKS];
	logic valid_r [2][BLOCKS];
	logic dirty_r [2][BLOCKS];
	logic lru_r [BLOCKS];

	// ------------------------------------------------------------
	// comparators, one per set
	// ------------------------------------------------------------
	for (genvar s = 0; s < ctp_pkg::SETS; s++) begin : g_cmp
		assign tif.tag_q[s] = tag_r[s][tif.index];
		assign tif.valid[s] = valid_r[s][tif.index];
		assign tif.dirty[s] = dirty_r[s][tif.index];
		assign tif.hit[s] = valid_r[s][tif.index] &&
			(tag_r[s][tif.index] == tif.tag);
	end
	assign tif.lru = lru_r[tif.index];

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// arrays are written in place; a next-value copy of the whole
	// array would only add area
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			for (int b = 0; b < BLOCKS; b++) begin
				valid_r[0][b] <= 1'b0;
				valid_r[1][b] <= 1'b0;
				dirty_r[0][b] <= 1'b0;
				dirty_r[1][b] <= 1'b0;
				lru_r[b] <= 1'b1;
			end
		end else if (clk_en_i) begin
			if (tif.fill_we) begin
				tag_r[tif.op_set][tif.index] <= tif.tag;
				valid_r[tif.op_set][tif.index] <= 1'b1;
				dirty_r[tif.op_set][tif.index] <= 1'b0;
			end
			if (tif.inval_we) begin
				valid_r[tif.op_set][tif.index] <= 1'b0;
			end
			if (tif.dirty_clr_we) begin
				dirty_r[tif.op_set][tif.index] <= 1'b0;
			end
			// set after clear so that a marking write is never lost
			if (tif.dirty_set_we) begin
				dirty_r[tif.op_set][tif.index] <= 1'b1;
			end
			if (tif.lru_we) begin
				lru_r[tif.index] <= tif.lru_val;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_fill_gives_hit: assert property (
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(tif.fill_we && clk_en_i) ##1
		(tif.index == $past(tif.index) && tif.tag == $past(tif.tag))
		|-> tif.hit[$past(tif.op_set)])
		else $error("filled block does not hit");
	a_reset_all_invalid: assert property (
		@(posedge core_clk_i) $rose(rst_n_i) |-> (tif.valid == 2'h0))
		else $error("block valid after reset");
endmodule

//--- ctp_bus_model.sv
// bus interface board model: grants after a wait, fills and takes blocks
module ctp_bus_model #(
	parameter int GRANT_WAIT = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic bus_request_i,
	input wire ctp_pkg::ctp_busop_t bus_opcode_i,
	input wire logic [31:0] bus_out_data_i,
	output logic bus_grant_o,
	output logic fill_valid_o,
	output logic [31:0] fill_in_bus_o,
	output logic bus_data_take_o,
	output logic [7:0] fills_o,
	output ctp_pkg::ctp_busop_t last_op_o,
	output logic [31:0] wb_dword2_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph;
	logic [2:0] cnt;
	int wt;
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ph <= 2'h0;
			cnt <= 3'h0;
			wt <= 0;
			bus_grant_o <= 1'b0;
			fill_valid_o <= 1'b0;
			fill_in_bus_o <= 32'h0000_0000;
			bus_data_take_o <= 1'b0;
			fills_o <= 8'h00;
			last_op_o <= ctp_pkg::BUSOP_NONE;
			wb_dword2_o <= 32'h0000_0000;
		end else begin
			// bus released between transfers: never leave a stale value
			if (!fill_valid_o)
				fill_in_bus_o <= ~fill_in_bus_o;
			case (ph)
			2'h0: if (bus_request_i) begin
				// a slow arbiter: the request must wait before the grant
				if (wt == GRANT_WAIT) begin
					bus_grant_o <= 1'b1;
					last_op_o <= bus_opcode_i;
					wt <= 0;
					ph <= 2'h1;
				end else
					wt <= wt + 1;
			end
			2'h1: begin
				bus_grant_o <= 1'b0;
				cnt <= 3'h0;
				ph <= 2'h2;
			end
			default: if (last_op_o == ctp_pkg::BUSOP_READ_PRIV) begin
				if (cnt < 3'h4) begin
					fill_valid_o <= 1'b1;
					fill_in_bus_o <= {fills_o, 5'h00, cnt[1:0], 1'b0,
						fills_o, 5'h00, cnt[1:0], 1'b1};
					cnt <= cnt + 3'h1;
				end else begin
					fill_valid_o <= 1'b0;
					fills_o <= fills_o + 8'h01;
					ph <= 2'h0;
				end
			end else if (bus_data_take_o) begin
				if (cnt == 3'h2)
					wb_dword2_o <= bus_out_data_i;
				cnt <= cnt + 3'h1;
				if (cnt == 3'h3) begin
					bus_data_take_o <= 1'b0;
					ph <= 2'h0;
				end
			end else
				bus_data_take_o <= 1'b1;
			endcase
		end
	end
endmodule

//--- two_way_cache_data_tag_path_test.sv
// self-checking bench of the two-set cache data and tag path
module two_way_cache_data_tag_path_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 0, rst_n_i = 0, start = 0, wr = 0;
	logic msg_up = 0, msg_lo = 0, src_sel = 0;
	logic [31:0] cpu_addr = 0, msg_word = 0, saddr = 0;
	logic snp = 0, stake = 0, dhn, abrt, bov;
	logic [15:0] wdata = 0, src_code = 0, rd, rdata;
	logic [1:0] par, parity;
	logic done, fail, req, lru, grant, fv, take, saw_fail;
	logic [3:0] en_n, seen_low;
	logic [31:0] bdata, fill, wb2, baddr;
	logic [7:0] fills;
	ctp_pkg::ctp_busop_t opcode, last_op;
	int mismatches = 0, comparisons = 0, cycles = 0;
	always #12.5 core_clk_i = ~core_clk_i;
	ctp_cache_path i_ctp_cache_path (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .clk_en_i(1'b1), .cpu_start_i(start),
		.cpu_write_i(wr), .cpu_address_bus_i(cpu_addr),
		.cpu_write_data_bus_i(wdata), .message_upper_select_i(msg_up),
		.message_lower_select_i(msg_lo), .source_code_select_i(src_sel),
		.message_word_i(msg_word), .source_code_i(src_code),
		.bus_grant_i(grant), .fill_valid_i(fv),
		.fill_in_bus_i(snp ? saddr : fill), .bus_data_take_i(take | stake),
		.snoop_valid_i(snp), .snoop_read_i(snp),
		.cpu_read_data_bus_o(rdata), .parity_o(parity), .cpu_done_o(done),
		.fail_o(fail), .double_hit_error_o(), .dirty_hit_n_o(dhn),
		.abort_o(abrt), .bus_request_o(req), .bus_opcode_o(opcode),
		.bus_address_o(baddr), .bus_out_data_o(bdata),
		.bus_out_valid_o(bov), .lru_set_select_o(lru),
		.set_a_upper_write_en_n_o(en_n[3]),
		.set_a_lower_write_en_n_o(en_n[2]),
		.set_b_upper_write_en_n_o(en_n[1]),
		.set_b_lower_write_en_n_o(en_n[0]));
	ctp_bus_model i_ctp_bus_model (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .bus_request_i(req), .bus_opcode_i(opcode),
		.bus_out_data_i(bdata), .bus_grant_o(grant), .fill_valid_o(fv),
		.fill_in_bus_o(fill), .bus_data_take_o(take), .fills_o(fills),
		.last_op_o(last_op), .wb_dword2_o(wb2));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input bit ok, input string what);
		comparisons++;
		if (!ok) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	function automatic logic [31:0] addr(logic [15:0] t, logic [7:0] i,
		logic [1:0] d, logic h);
		return {5'h00, t, i, d, h};
	endfunction
	// start and write are held until done, as a frozen cpu would
	task access(input logic [31:0] a, input logic w, input logic [15:0] d);
		int n;
		cpu_addr = a;
		wr = w;
		wdata = d;
		start = 1'b1;
		seen_low = 4'h0;
		saw_fail = 1'b0;
		n = 0;
		do begin
			@(posedge core_clk_i);
			#1;
			n++;
			saw_fail |= (fail === 1'b1);
			seen_low |= ~en_n;
		end while (done !== 1'b1 && n < 400);
		check(n < 400, "no completion");
		rd = rdata;
		par = parity;
		start = 1'b0;
		@(posedge core_clk_i);
		#1;
	endtask
	task read_check(input logic [31:0] a, input logic [15:0] e,
		input logic f);
		access(a, 1'b0, 16'h0000);
		check(rd === e, "read word");
		check(par === {~^e[15:8], ~^e[7:0]}, "parity");
		check(saw_fail === f, "fail level");
	endtask
	task mux_check(input logic s, u, l, input logic [15:0] e);
		src_sel = s;
		msg_up = u;
		msg_lo = l;
		repeat (2) @(posedge core_clk_i);
		#1;
		check(rdata === e, "mux word");
		check(parity === {~^e[15:8], ~^e[7:0]}, "mux parity");
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		check(fail === 1'b0 && done === 1'b0, "reset flags");
		check(opcode === ctp_pkg::BUSOP_NONE, "reset opcode");
		check(parity === 2'h3 && rdata === 16'h0000, "reset word");
	endtask
	task t_clean_miss;
		read_check(addr(16'h1234, 8'h05, 2'h2, 1'b1), 16'h0005, 1'b1);
		check(last_op === ctp_pkg::BUSOP_READ_PRIV, "fetch op");
		check(seen_low === 4'hC, "fill into set a");
		read_check(addr(16'h1234, 8'h05, 2'h3, 1'b0), 16'h0006, 1'b0);
		check(seen_low === 4'h0, "no write on read");
	endtask
	task t_write_hit;
		access(addr(16'h1234, 8'h05, 2'h2, 1'b1), 1'b1, 16'hBEEF);
		check(saw_fail === 1'b0, "write hit fail");
		check(seen_low === 4'h4, "lower word of a");
		read_check(addr(16'h1234, 8'h05, 2'h2, 1'b1), 16'hBEEF, 1'b0);
	endtask
	task t_dirty_miss;
		read_check(addr(16'h4321, 8'h05, 2'h0, 1'b1), 16'h0101, 1'b1);
		check(seen_low === 4'h3, "fill into set b");
		read_check(addr(16'h7777, 8'h05, 2'h1, 1'b1), 16'h0203, 1'b1);
		check(wb2 === 32'h0004_BEEF, "written back block");
		check(last_op === ctp_pkg::BUSOP_READ_PRIV, "fetch after send");
		read_check(addr(16'h4321, 8'h05, 2'h0, 1'b1), 16'h0101, 1'b0);
	endtask
	task t_mux;
		src_code = 16'h3C5A;
		msg_word = 32'h9876_1234;
		mux_check(1'b1, 1'b0, 1'b0, 16'h3C5A);
		mux_check(1'b0, 1'b1, 1'b0, 16'h9876);
		mux_check(1'b0, 1'b0, 1'b1, 16'h1234);
		mux_check(1'b0, 1'b0, 1'b0, 16'h0101);
		check(baddr === addr(16'h4321, 8'h05, 2'h0, 1'b0), "bus addr");
	endtask
	// a dirty block read by another module is served, then refetched
	task t_snoop;
		access(addr(16'h4321, 8'h05, 2'h1, 1'b0), 1'b1, 16'hA5A5);
		check(seen_low === 4'h2, "upper word of b");
		saddr = addr(16'h4321, 8'h05, 2'h0, 1'b0);
		snp = 1'b1;
		@(posedge core_clk_i);
		#1;
		snp = 1'b0;
		check(dhn === 1'b0, "dirty hit");
		@(posedge core_clk_i);
		#1;
		check(abrt === 1'b1 && bov === 1'b1, "act as memory");
		check(lru === 1'b0 && bdata === 32'h0100_0101, "set b dword");
		stake = 1'b1;
		@(posedge core_clk_i);
		#1;
		check(bdata === 32'hA5A5_0103, "served dword 1");
		repeat (3) @(posedge core_clk_i);
		#1;
		stake = 1'b0;
		check(bov === 1'b0, "back to idle");
		read_check(addr(16'h4321, 8'h05, 2'h0, 1'b1), 16'h0301, 1'b1);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize;
		end
	end
	initial begin
		repeat (5) @(posedge core_clk_i);
		#1;
		t_reset;
		rst_n_i = 1'b1;
		t_clean_miss;
		t_write_hit;
		t_dirty_miss;
		t_mux;
		t_snoop;
		summarize;
	end
endmodule
